// ==== pkg/qde_pkg.sv ====
package qde_pkg;

   // Bus and block geometry.
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam int AXI_STRB_W = AXI_DATA_W / 8;
   localparam int ENC_N      = 2;
   localparam int IN_N       = 2 * ENC_N;
   localparam int COUNT_W    = 32;

   // Threshold code: full scale of the threshold converter is 5 V.
   localparam int THR_W        = 8;
   localparam int THR_FULL_MV  = 5000;
   localparam int THR_RESET_MV = 2500;
   localparam logic [THR_W-1:0] THR_RESET =
      THR_W'(THR_RESET_MV * (1 << THR_W) / THR_FULL_MV);

   // Register byte offsets.
   localparam logic [AXI_ADDR_W-1:0] REG_CTRL       = 8'h00;
   localparam logic [AXI_ADDR_W-1:0] REG_LEVELS     = 8'h04;
   localparam logic [AXI_ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
   localparam logic [AXI_ADDR_W-1:0] REG_IRQ_MASK   = 8'h0c;
   localparam logic [AXI_ADDR_W-1:0] REG_COUNT_1    = 8'h10;
   localparam logic [AXI_ADDR_W-1:0] REG_COUNT_2    = 8'h14;

   // Control register fields.
   localparam int CTRL_THR_LSB  = 0;
   localparam int CTRL_GATE_LSB = 8;
   localparam logic [ENC_N-1:0] GATE_RESET = 2'h3;

   // Level register fields.
   localparam int LVL_SW_LSB    = 0;
   localparam int LVL_PHASE_LSB = 4;

   // Interrupt status and mask fields.
   localparam int IRQ_W        = 8;
   localparam int IRQ_SW_LSB   = 0;
   localparam int IRQ_BAD_LSB  = 4;
   localparam int IRQ_WRAP_LSB = 6;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 8'h00;

   // Counter limits, signed two's complement.
   localparam logic [COUNT_W-1:0] COUNT_MAX = 32'h7fffffff;
   localparam logic [COUNT_W-1:0] COUNT_MIN = 32'h80000000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : qde_pkg

// ==== pkg/qde_step_if.sv ====
`timescale 1ns/1ps
interface qde_step_if;
   logic phase_a;
   logic phase_b;
   logic hold;
   logic step_up;
   logic step_down;
   logic step_bad;

   modport feeder  (output phase_a, phase_b, hold, input step_up, step_down, step_bad);
   modport decoder (input phase_a, phase_b, hold, output step_up, step_down, step_bad);
endinterface : qde_step_if

// ==== design/qde_quad_decoder.sv ====
`timescale 1ns/1ps
module qde_quad_decoder
   import qde_pkg::*;
(
   // Clock and reset
   input  wire logic   aclk,
   input  wire logic   aresetn,
   // Synchronised phases in, count steps out
   qde_step_if.decoder step
);

   typedef struct packed {
      logic prev_a;
      logic prev_b;
      logic primed;
      logic up;
      logic down;
      logic bad;
   } qde_dec_state_t;

   localparam qde_dec_state_t DEC_RESET = '0;

   qde_dec_state_t state;
   qde_dec_state_t next_state;
   logic           moved_a;
   logic           moved_b;
   logic           reverse;

   always_comb begin
      next_state      = state;
      moved_a         = step.phase_a ^ state.prev_a;
      moved_b         = step.phase_b ^ state.prev_b;
      reverse         = state.prev_a ^ step.phase_b;
      next_state.prev_a = step.phase_a;
      next_state.prev_b = step.phase_b;
      next_state.primed = 1'b1;
      next_state.up     = 1'b0;
      next_state.down   = 1'b0;
      next_state.bad    = 1'b0;
      // The first sample after reset only seeds the history, it never counts.
      // switch blocks counting
      if (state.primed && !step.hold) begin
         if (moved_a && moved_b) begin
            next_state.bad = 1'b1;
         end else if (moved_a || moved_b) begin
            next_state.up   = ~reverse;
            next_state.down = reverse;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= DEC_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign step.step_up   = state.up;
   assign step.step_down = state.down;
   assign step.step_bad  = state.bad;

endmodule : qde_quad_decoder

// ==== design/qde_encoder_top.sv ====
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module qde_encoder_top
   import qde_pkg::*;
(
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // AXI4-Lite write address channel
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // AXI4-Lite write data channel
   input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
   input  wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // AXI4-Lite write response channel
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read address channel
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // AXI4-Lite read data channel
   output logic [AXI_DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Threshold comparator outputs, high when above the programmed level
   input  wire logic [ENC_N-1:0]      phase_a_input,
   input  wire logic [ENC_N-1:0]      phase_b_input,
   // Fixed-level comparator outputs, high when above the switch level
   input  wire logic [ENC_N-1:0]      limit_clear_a,
   input  wire logic [ENC_N-1:0]      limit_clear_b,
   // Threshold converter code
   output logic [THR_W-1:0]           threshold_code,
   // Encoder state towards the speed and position logic
   output logic [COUNT_W-1:0]         position_count_1,
   output logic [COUNT_W-1:0]         position_count_2,
   output logic [IN_N-1:0]            switch_detect,
   // Interrupt
   output logic                       irq
);

   typedef struct packed {
      logic [IN_N-1:0]                phase_meta;
      logic [IN_N-1:0]                phase_sync;
      logic [IN_N-1:0]                sw_meta;
      logic [IN_N-1:0]                sw_sync;
      logic [IN_N-1:0]                sw_seen;
      logic [THR_W-1:0]               threshold;
      logic [ENC_N-1:0]               gate_en;
      logic [IRQ_W-1:0]               irq_status;
      logic [IRQ_W-1:0]               irq_mask;
      logic [ENC_N-1:0][COUNT_W-1:0]  count;
      logic [AXI_ADDR_W-1:0]          aw_addr;
      logic                           aw_held;
      logic                           w_held;
      logic [AXI_DATA_W-1:0]          w_data;
      logic [AXI_STRB_W-1:0]          w_strb;
      logic                           b_valid;
      logic [1:0]                     b_resp;
      logic                           r_valid;
      logic [1:0]                     r_resp;
      logic [AXI_DATA_W-1:0]          r_data;
   } qde_top_state_t;

   localparam qde_top_state_t TOP_RESET = '{
      threshold: THR_RESET,
      gate_en:   GATE_RESET,
      irq_mask:  IRQ_MASK_RESET,
      default:   '0
   };

   qde_top_state_t              state;
   qde_top_state_t              next_state;
   logic [IN_N-1:0]             phase_raw;
   logic [IN_N-1:0]             limit_raw;
   logic [ENC_N-1:0]            step_up;
   logic [ENC_N-1:0]            step_down;
   logic [ENC_N-1:0]            step_bad;
   logic [IRQ_W-1:0]            events;
   logic [IRQ_W-1:0]            status_clear;
   logic [AXI_DATA_W-1:0]       ctrl_word;
   logic [AXI_DATA_W-1:0]       levels_word;
   logic [AXI_DATA_W-1:0]       merged;
   logic [COUNT_W:0]            stepped;

   // Byte-lane merge of a write into the current register value.
   function automatic logic [AXI_DATA_W-1:0] merge_strb(
      input logic [AXI_DATA_W-1:0] old_word,
      input logic [AXI_DATA_W-1:0] new_word,
      input logic [AXI_STRB_W-1:0] strb
   );
      logic [AXI_DATA_W-1:0] result;
      result = old_word;
      for (int i = 0; i < AXI_STRB_W; i++) begin
         if (strb[i]) begin
            result[i*8 +: 8] = new_word[i*8 +: 8];
         end
      end
      return result;
   endfunction : merge_strb

   // One count step; the top bit reports a wrap to zero at either limit.
   function automatic logic [COUNT_W:0] count_step(
      input logic [COUNT_W-1:0] value,
      input logic               up,
      input logic               down
   );
      logic [COUNT_W:0] result;
      result = {1'b0, value};
      if (up) begin
         if (value == COUNT_MAX) begin
            result = {1'b1, {COUNT_W{1'b0}}};
         end else begin
            result = {1'b0, value + COUNT_W'(1)};
         end
      end else if (down) begin
         if (value == COUNT_MIN) begin
            result = {1'b1, {COUNT_W{1'b0}}};
         end else begin
            result = {1'b0, value - COUNT_W'(1)};
         end
      end
      return result;
   endfunction : count_step

   // channel inputs map to switches
   // Bit order is encoder 1 A, encoder 1 B, encoder 2 A, encoder 2 B, which
   // makes switch n sit on bit n-1.
   // only two channels used
   assign phase_raw = {phase_b_input[1], phase_a_input[1],
                       phase_b_input[0], phase_a_input[0]};
   assign limit_raw = {limit_clear_b[1], limit_clear_a[1],
                       limit_clear_b[0], limit_clear_a[0]};

   // one count per clock
   // A full count takes a single clock, so at 250 MHz the decoder keeps up with
   // rates far above the minimum; the limit is the comparator front end.
   qde_step_if step_bus [ENC_N] ();

   for (genvar e = 0; e < ENC_N; e++) begin : g_dec
      assign step_bus[e].phase_a = state.phase_sync[2*e];
      assign step_bus[e].phase_b = state.phase_sync[2*e+1];
      // gate on active switch
      // The gate lasts one sample past the release. The phase level and the switch
      // flag come back in the same sample, and that return must not count as a step.
      assign step_bus[e].hold    = state.gate_en[e]
                                   & (|(state.sw_sync[2*e +: 2] | state.sw_seen[2*e +: 2]));
      assign step_up[e]          = step_bus[e].step_up;
      assign step_down[e]        = step_bus[e].step_down;
      assign step_bad[e]         = step_bus[e].step_bad;

      qde_quad_decoder u_dec (
         .aclk    (aclk),
         .aresetn (aresetn),
         .step    (step_bus[e])
      );
   end

   assign ctrl_word   = AXI_DATA_W'({state.gate_en, state.threshold});
   assign levels_word = AXI_DATA_W'({state.phase_sync, state.sw_sync});

   always_comb begin
      next_state   = state;
      events       = '0;
      status_clear = '0;
      merged       = '0;
      stepped      = '0;

      next_state.phase_meta = phase_raw;
      next_state.phase_sync = state.phase_meta;
      next_state.sw_meta    = ~limit_raw;
      next_state.sw_sync    = state.sw_meta;
      next_state.sw_seen    = state.sw_sync;

      // A switch event fires on the closing of a switch, not while it stays on.
      events[IRQ_SW_LSB +: IN_N] = state.sw_sync & ~state.sw_seen;

      for (int e = 0; e < ENC_N; e++) begin
         events[IRQ_BAD_LSB + e] = step_bad[e];
         stepped = count_step(state.count[e], step_up[e], step_down[e]);
         next_state.count[e]      = stepped[COUNT_W-1:0];
         events[IRQ_WRAP_LSB + e] = stepped[COUNT_W];
      end

      // Write address and data are taken independently, in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         next_state.aw_addr = s_axi_awaddr;
         next_state.aw_held = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_state.w_data = s_axi_wdata;
         next_state.w_strb = s_axi_wstrb;
         next_state.w_held = 1'b1;
      end
      if (state.b_valid && s_axi_bready) begin
         next_state.b_valid = 1'b0;
      end

      // A counter load is applied after the step, so software wins the race.
      if (state.aw_held && state.w_held) begin
         next_state.aw_held = 1'b0;
         next_state.w_held  = 1'b0;
         next_state.b_valid = 1'b1;
         next_state.b_resp  = RESP_OKAY;
         unique case (state.aw_addr)
            REG_CTRL: begin
               merged = merge_strb(ctrl_word, state.w_data, state.w_strb);
               next_state.threshold = merged[CTRL_THR_LSB +: THR_W];
               next_state.gate_en   = merged[CTRL_GATE_LSB +: ENC_N];
            end
            REG_IRQ_MASK: begin
               merged = merge_strb(AXI_DATA_W'(state.irq_mask), state.w_data,
                                   state.w_strb);
               next_state.irq_mask = merged[IRQ_W-1:0];
            end
            REG_COUNT_1: begin
               next_state.count[0] = merge_strb(state.count[0], state.w_data,
                                                state.w_strb);
            end
            REG_COUNT_2: begin
               next_state.count[1] = merge_strb(state.count[1], state.w_data,
                                                state.w_strb);
            end
            REG_LEVELS, REG_IRQ_STATUS: begin
               // Read-only words accept and drop the write.
               next_state.b_resp = RESP_OKAY;
            end
            default: begin
               next_state.b_resp = RESP_SLVERR;
            end
         endcase
      end

      if (state.r_valid && s_axi_rready) begin
         next_state.r_valid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_state.r_valid = 1'b1;
         next_state.r_resp  = RESP_OKAY;
         unique case (s_axi_araddr)
            REG_CTRL:       next_state.r_data = ctrl_word;
            REG_LEVELS:     next_state.r_data = levels_word;
            REG_IRQ_STATUS: begin
               next_state.r_data = AXI_DATA_W'(state.irq_status);
               status_clear      = state.irq_status;
            end
            REG_IRQ_MASK:   next_state.r_data = AXI_DATA_W'(state.irq_mask);
            REG_COUNT_1:    next_state.r_data = state.count[0];
            REG_COUNT_2:    next_state.r_data = state.count[1];
            default: begin
               next_state.r_data = '0;
               next_state.r_resp = RESP_SLVERR;
            end
         endcase
      end

      // A new event in the clearing cycle survives the read.
      next_state.irq_status = (state.irq_status & ~status_clear) | events;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= TOP_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Handshake readies; each channel refuses while its previous item waits.
   assign s_axi_awready = ~state.aw_held & ~state.b_valid;
   assign s_axi_wready  = ~state.w_held & ~state.b_valid;
   assign s_axi_arready = ~state.r_valid;
   assign s_axi_bvalid  = state.b_valid;
   assign s_axi_bresp   = state.b_resp;
   assign s_axi_rvalid  = state.r_valid;
   assign s_axi_rresp   = state.r_resp;
   assign s_axi_rdata   = state.r_data;

   assign threshold_code   = state.threshold;
   assign position_count_1 = state.count[0];
   assign position_count_2 = state.count[1];
   assign switch_detect    = state.sw_sync;
   assign irq              = |(state.irq_status & state.irq_mask);

endmodule : qde_encoder_top

// ==== testbench/qde_encoder_top_chk.sv ====
`timescale 1ns/1ps
module qde_chk
   import qde_pkg::*;
(
   // Clock and reset
   input wire logic                  aclk,
   input wire logic                  aresetn,
   // Bus handshakes
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic                  s_axi_rvalid,
   // Encoder lines and results
   input wire logic [ENC_N-1:0]      phase_a_input,
   input wire logic [ENC_N-1:0]      phase_b_input,
   input wire logic [ENC_N-1:0]      limit_clear_a,
   input wire logic [ENC_N-1:0]      limit_clear_b,
   input wire logic [THR_W-1:0]      threshold_code,
   input wire logic [COUNT_W-1:0]    position_count_1,
   input wire logic [IN_N-1:0]       switch_detect,
   input wire logic                  irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_RST_VALUES: assert property (disable iff (1'b0)
      !aresetn |=> threshold_code == 8'h80 && position_count_1 == 32'h0
         && irq == 1'b0 && switch_detect == 4'h0)
      else $error("reset state wrong");
   AST_COUNT_UP: assert property (
      $rose(phase_a_input[0]) && !phase_b_input[0] && $stable(phase_b_input[0])
         && limit_clear_a[0] && limit_clear_b[0]
      |-> ##4 position_count_1 == $past(position_count_1, 4) + 32'h1)
      else $error("count did not rise by one");
   AST_COUNT_DOWN: assert property (
      $rose(phase_b_input[0]) && !phase_a_input[0] && $stable(phase_a_input[0])
         && limit_clear_a[0] && limit_clear_b[0]
      |-> ##4 position_count_1 == $past(position_count_1, 4) - 32'h1)
      else $error("count did not fall by one");
   AST_W_BUSY: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_B_ONE: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_R_ANSWER: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   AST_SW_FIRST: assert property (
      $fell(limit_clear_a[0]) |-> ##[1:3] switch_detect[0])
      else $error("switch one not flagged");
   AST_SW_FOURTH: assert property (
      $fell(limit_clear_b[1]) |-> ##[1:3] switch_detect[3])
      else $error("switch four not flagged");
endmodule : qde_chk

bind qde_encoder_top qde_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .phase_a_input, .phase_b_input, .limit_clear_a, .limit_clear_b, .threshold_code,
   .position_count_1, .switch_detect, .irq);

// ==== testbench/qde_enc_model.sv ====
`timescale 1ns/1ps
module qde_enc_model (
   // Clock
   input  wire logic       aclk,
   // Resolved lines towards the block
   output logic [1:0]      phase_a_input,
   output logic [1:0]      phase_b_input,
   output logic [1:0]      limit_clear_a,
   output logic [1:0]      limit_clear_b
);
   logic [1:0] pos [2];
   logic [1:0] swap;
   logic [1:0] direct;
   logic [3:0] sw_on;
   logic [1:0] lva;
   logic [1:0] lvb;

   initial begin
      pos[0] = 2'h0;
      pos[1] = 2'h0;
      swap   = 2'h0;
      direct = 2'h0;
      sw_on  = 4'h0;
   end

   always_comb begin
      for (int e = 0; e < 2; e++) begin
         lva[e] = swap[e] ? pos[e][1] : ^pos[e];
         lvb[e] = swap[e] ? ^pos[e] : pos[e][1];
         phase_a_input[e] = lva[e] & !sw_on[2*e];
         phase_b_input[e] = lvb[e] & !sw_on[2*e+1];
         limit_clear_a[e] = direct[e] ? lva[e] : !sw_on[2*e];
         limit_clear_b[e] = direct[e] ? lvb[e] : !sw_on[2*e+1];
      end
   end

   task automatic step(input int e, input int n, input bit up);
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         pos[e] <= up ? pos[e] + 2'h1 : pos[e] - 2'h1;
         repeat (7) @(posedge aclk);
      end
   endtask : step

   // Both lines move at once, which a real encoder only does when glitching.
   task automatic jump(input int e);
      @(posedge aclk);
      pos[e] <= pos[e] + 2'h2;
      repeat (7) @(posedge aclk);
   endtask : jump
endmodule : qde_enc_model

// ==== testbench/dual_quadrature_encoder_input_test.sv ====
`timescale 1ns/1ps
module dual_quadrature_encoder_input_test
   import qde_pkg::*;
;
   logic                  aclk = 1'b0;
   logic                  aresetn = 1'b0;
   logic [AXI_ADDR_W-1:0] s_axi_awaddr = 8'h00;
   logic                  s_axi_awvalid = 1'b0;
   logic                  s_axi_awready;
   logic [AXI_DATA_W-1:0] s_axi_wdata = 32'h0;
   logic [AXI_STRB_W-1:0] s_axi_wstrb = 4'hf;
   logic                  s_axi_wvalid = 1'b0;
   logic                  s_axi_wready;
   logic [1:0]            s_axi_bresp;
   logic [1:0]            s_axi_rresp;
   logic                  s_axi_bvalid;
   logic                  s_axi_bready = 1'b1;
   logic [AXI_ADDR_W-1:0] s_axi_araddr = 8'h00;
   logic                  s_axi_arvalid = 1'b0;
   logic                  s_axi_arready;
   logic [AXI_DATA_W-1:0] s_axi_rdata;
   logic                  s_axi_rvalid;
   logic                  s_axi_rready = 1'b1;
   logic [ENC_N-1:0]      phase_a_input, phase_b_input, limit_clear_a, limit_clear_b;
   logic [THR_W-1:0]      threshold_code;
   logic [COUNT_W-1:0]    position_count_1, position_count_2;
   logic [IN_N-1:0]       switch_detect;
   logic                  irq;
   int                    errors = 0;
   int                    n_tests = 0;

   qde_encoder_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phase_a_input,
      .phase_b_input, .limit_clear_a, .limit_clear_b, .threshold_code,
      .position_count_1, .position_count_2, .switch_detect, .irq);
   qde_enc_model u_enc (.aclk, .phase_a_input, .phase_b_input, .limit_clear_a,
      .limit_clear_b);

   always #2 aclk = ~aclk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   // Response ready is held high throughout, so every answer is taken at once.
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      while (!s_axi_bvalid) @(posedge aclk);
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
   endtask : axw

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      check(what, s_axi_rdata & m, exp);
   endtask : rchk

   initial begin
      repeat (5000) @(posedge aclk);
      errors++;
      conclude();
   end

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check("thr", {24'h0, threshold_code}, 32'h80);
      rchk("ctrl", REG_CTRL, '1, 32'h380, RESP_OKAY);
      rchk("mask", REG_IRQ_MASK, '1, 32'h0, RESP_OKAY);
      rchk("hole", 8'h18, '1, 32'h0, RESP_SLVERR);
      axw(8'h18, 32'h1, RESP_SLVERR);
      axw(8'h02, 32'h1, RESP_SLVERR);
      axw(REG_CTRL, 32'h340, RESP_OKAY);
      check("thr", {24'h0, threshold_code}, 32'h40);
      u_enc.step(0, 8, 1'b1);
      check("count1", position_count_1, 32'h8);
      rchk("count1 reg", REG_COUNT_1, '1, 32'h8, RESP_OKAY);
      u_enc.step(0, 3, 1'b0);
      check("count1", position_count_1, 32'h5);
      u_enc.step(0, 1, 1'b1);
      u_enc.swap <= 2'h1;
      u_enc.step(0, 4, 1'b1);
      check("count1", position_count_1, 32'h2);
      u_enc.jump(0);
      check("count1", position_count_1, 32'h2);
      check("irq", {31'h0, irq}, 32'h0);
      axw(REG_IRQ_MASK, 32'h10, RESP_OKAY);
      @(posedge aclk);
      check("irq", {31'h0, irq}, 32'h1);
      rchk("status", REG_IRQ_STATUS, 32'hf0, 32'h10, RESP_OKAY);
      rchk("status", REG_IRQ_STATUS, 32'hf0, 32'h0, RESP_OKAY);
      check("irq", {31'h0, irq}, 32'h0);
      axw(REG_COUNT_2, 32'h7fffffff, RESP_OKAY);
      u_enc.step(1, 1, 1'b1);
      check("count2", position_count_2, 32'h0);
      rchk("status", REG_IRQ_STATUS, 32'hc0, 32'h80, RESP_OKAY);
      u_enc.step(1, 1, 1'b0);
      check("count2", position_count_2, 32'hffffffff);
      axw(REG_COUNT_2, 32'h80000000, RESP_OKAY);
      u_enc.step(1, 1, 1'b0);
      check("count2", position_count_2, 32'h0);
      for (int i = 0; i < 4; i++) begin
         u_enc.sw_on <= 4'h1 << i;
         repeat (6) @(posedge aclk);
         check("switch", {28'h0, switch_detect}, 32'h1 << i);
         rchk("levels", REG_LEVELS, 32'hf, 32'h1 << i, RESP_OKAY);
         u_enc.sw_on <= 4'h0;
         repeat (6) @(posedge aclk);
      end
      check("count2", position_count_2, 32'h0);
      u_enc.sw_on <= 4'h4;
      u_enc.step(1, 4, 1'b1);
      check("count2", position_count_2, 32'h0);
      u_enc.sw_on <= 4'h0;
      u_enc.step(1, 4, 1'b1);
      check("count2", position_count_2, 32'h4);
      // With direct wiring the switch lines follow the phase lines, so gating must be off.
      axw(REG_CTRL, 32'h40, RESP_OKAY);
      u_enc.direct <= 2'h3;
      u_enc.step(1, 4, 1'b1);
      check("count2", position_count_2, 32'h8);
      rchk("levels", REG_LEVELS, 32'hf0, 32'h80, RESP_OKAY);
      conclude();
   end
endmodule : dual_quadrature_encoder_input_test
